// [inc/msd_pkg.sv]
/*
  constants, types and the register map of the memory reference and
  shift/skip decoder.
  assumes one clock, an avalon-mm slave port for software and an
  avalon-mm master port towards main memory.
*/
package msd_pkg;

  // ==========================================================
  // register map (byte offsets on the avalon slave)
  localparam logic [4:0] REG_INSTR  = 5'h00;
  localparam logic [4:0] REG_ACC1   = 5'h04;
  localparam logic [4:0] REG_ACC2   = 5'h08;
  localparam logic [4:0] REG_FLAGS  = 5'h0c;
  localparam logic [4:0] REG_PC     = 5'h10;
  localparam logic [4:0] REG_BASE   = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;

  // ==========================================================
  // flag and status register fields and reset values
  localparam int FLAG_EXTEND    = 0;
  localparam int FLAG_OVERFLOW  = 1;
  localparam int FLAG_BASE_MODE = 2;
  localparam int STAT_SKIP      = 0;
  localparam int STAT_BUSY      = 1;
  localparam logic [15:0] ACC_RESET  = 16'h0000;
  localparam logic [14:0] PC_RESET   = 15'h0000;
  localparam logic [15:0] BASE_RESET = 16'h0000;

  // ==========================================================
  // instruction word fields
  localparam int IR_INDIRECT  = 15;
  localparam int IR_ACC_SEL   = 11;
  localparam int IR_PAGE      = 10;
  localparam int IR_GROUP     = 10;
  localparam int IR_EN_FIRST  = 9;
  localparam int IR_CLR_EXT   = 5;
  localparam int IR_EN_SECOND = 4;
  localparam int IR_SKIP_EVEN = 3;
  localparam int IR_SKIP_EXT  = 5;
  localparam int IR_SKIP_SIGN = 4;
  localparam int IR_INC       = 2;
  localparam int IR_SKIP_ZERO = 1;
  localparam int IR_REVERSE   = 0;

  // ==========================================================
  // memory reference opcodes, bits 14..11
  localparam logic [3:0] OP_AND_ONE   = 4'h2;
  localparam logic [3:0] OP_SUB_JUMP  = 4'h3;
  localparam logic [3:0] OP_XOR_ONE   = 4'h4;
  localparam logic [3:0] OP_JUMP      = 4'h5;
  localparam logic [3:0] OP_IOR_ONE   = 4'h6;
  localparam logic [3:0] OP_INC_SKIP  = 4'h7;
  localparam logic [3:0] OP_ADD_ONE   = 4'h8;
  localparam logic [3:0] OP_ADD_TWO   = 4'h9;
  localparam logic [3:0] OP_CMP_ONE   = 4'ha;
  localparam logic [3:0] OP_CMP_TWO   = 4'hb;
  localparam logic [3:0] OP_LOAD_ONE  = 4'hc;
  localparam logic [3:0] OP_LOAD_TWO  = 4'hd;
  localparam logic [3:0] OP_STORE_ONE = 4'he;
  localparam logic [3:0] OP_STORE_TWO = 4'hf;

  // ==========================================================
  // shift/rotate position codes
  localparam logic [2:0] SH_ARITH_LEFT  = 3'h0;
  localparam logic [2:0] SH_ARITH_RIGHT = 3'h1;
  localparam logic [2:0] SH_ROT_LEFT    = 3'h2;
  localparam logic [2:0] SH_ROT_RIGHT   = 3'h3;
  localparam logic [2:0] SH_LEFT_CLR    = 3'h4;
  localparam logic [2:0] SH_EXT_RIGHT   = 3'h5;
  localparam logic [2:0] SH_EXT_LEFT    = 3'h6;
  localparam logic [2:0] SH_ROT_FOUR    = 3'h7;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_DECODE  = 3'b001,
    PH_POINTER = 3'b010,
    PH_OPERAND = 3'b011,
    PH_STORE   = 3'b100
  } msd_phase_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [14:0] address;
    logic [15:0] writedata;
  } msd_mem_cmd_type;

  typedef struct packed {
    msd_phase_type phase;
    logic [15:0]   ir;
    logic [15:0]   acc_one;
    logic [15:0]   acc_two;
    logic          extend;
    logic          overflow;
    logic          base_mode;
    logic [14:0]   pc;
    logic [15:0]   base;
    logic [14:0]   ea;
    logic [15:0]   wdata;
    logic          skip;
    logic          bus_ack;
    logic [31:0]   rdata;
  } msd_state_type;

endpackage

// [rtl/msd_decoder.sv]
/*
  executes one instruction word at a time: memory reference with
  paging, base-relative and indirect addressing, and the shift/rotate
  and alter/skip register groups.
  assumes an avalon-mm master for software and avalon-mm memory with
  waitrequest; accumulators stand at memory words 0 and 1.
*/
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module msd_decoder (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic [4:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  output msd_pkg::msd_mem_cmd_type       mem_cmd,
  input  wire logic [15:0]               avm_readdata,
  input  wire logic                      avm_waitrequest
);
  import msd_pkg::*;

  msd_state_type s;
  msd_state_type next_s;
  logic          acc_hit;
  logic          word_ready;
  logic [15:0]   word;
  logic [3:0]    op;
  logic          done;
  logic          take_skip;
  logic          jump;
  logic [14:0]   jump_pc;
  logic          have_ea;
  logic [14:0]   ea_val;
  logic [15:0]   sel_acc;
  logic [16:0]   sum;
  logic [16:0]   step;
  logic [18:0]   alter;
  logic          srg_skip;

  // ==========================================================
  // helpers
  function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] d, logic [3:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // one shift/rotate position: returns {extend, value}
  function automatic logic [16:0] shift_step(logic [2:0] code, logic en, logic [15:0] v,
                                             logic e);
    logic [15:0] r;
    logic        ne;
    r  = v;
    ne = e;
    unique case (code)
      SH_ARITH_LEFT:  r = {v[15], v[13:0], 1'b0};
      SH_ARITH_RIGHT: r = {v[15], v[15], v[14:1]};
      SH_ROT_LEFT:    r = {v[14:0], v[15]};
      SH_ROT_RIGHT:   r = {v[0], v[15:1]};
      SH_LEFT_CLR:    r = {1'b0, v[13:0], 1'b0};
      SH_EXT_RIGHT: begin
        r  = {e, v[15:1]};
        ne = v[0];
      end
      SH_EXT_LEFT: begin
        r  = {v[14:0], e};
        ne = v[15];
      end
      SH_ROT_FOUR:    r = {v[11:0], v[15:12]};
    endcase
    // extend moves even when the position is disabled
    return {ne, en ? r : v};
  endfunction

  // alter/skip word: returns {skip, overflow, extend, value}
  function automatic logic [18:0] alter_skip(logic [15:0] ir, logic [15:0] acc, logic e,
                                             logic ov);
    logic [15:0] v;
    logic        ne;
    logic        nov;
    logic        rev;
    logic        c_ext;
    logic        c_sign;
    logic        c_even;
    logic        c_zero;
    logic        sk;
    v   = acc;
    ne  = e;
    nov = ov;
    rev = ir[IR_REVERSE];
    unique case (ir[9:8])
      2'b00: v = acc;
      2'b01: v = 16'h0000;
      2'b10: v = ~acc;
      2'b11: v = 16'hffff;
    endcase
    unique case (ir[7:6])
      2'b00: ne = e;
      2'b01: ne = 1'b0;
      2'b10: ne = ~e;
      2'b11: ne = 1'b1;
    endcase
    c_ext  = ir[IR_SKIP_EXT] & (ne == rev);
    c_sign = ir[IR_SKIP_SIGN] & (v[15] == rev);
    c_even = ir[IR_SKIP_EVEN] & (v[0] == rev);
    if (ir[IR_INC]) begin
      nov = nov | (v == 16'h7fff);
      ne  = ne | (v == 16'hffff);
      v   = 16'(v + 16'h0001);
    end
    c_zero = ir[IR_SKIP_ZERO] & ((|v) == rev);
    // any condition skips, reverse-skip special cases
    if (!rev)
      sk = c_ext | c_sign | c_even | c_zero;
    else if (!(ir[IR_SKIP_EXT] | ir[IR_SKIP_SIGN] | ir[IR_SKIP_EVEN] | ir[IR_SKIP_ZERO]))
      sk = 1'b1;
    else if (ir[IR_SKIP_SIGN] & ir[IR_SKIP_EVEN])
      sk = (c_sign & c_even) | c_ext | c_zero;
    else
      sk = c_ext | c_sign | c_even | c_zero;
    return {sk, nov, ne, v};
  endfunction

  // ==========================================================
  // memory side
  // words 0 and 1 resolve to the accumulators
  assign acc_hit    = (s.ea[14:1] == 14'h0000);
  assign word       = acc_hit ? (s.ea[0] ? s.acc_two : s.acc_one) : avm_readdata;
  assign word_ready = acc_hit | ~avm_waitrequest;
  assign op         = s.ir[14:11];

  assign mem_cmd.read      = (s.phase == PH_POINTER || s.phase == PH_OPERAND) & ~acc_hit;
  assign mem_cmd.write     = (s.phase == PH_STORE) & ~acc_hit;
  assign mem_cmd.address   = s.ea;
  assign mem_cmd.writedata = s.wdata;

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = ~s.bus_ack;

  // ==========================================================
  // next state
  always_comb begin
    next_s    = s;
    done      = 1'b0;
    take_skip = 1'b0;
    jump      = 1'b0;
    jump_pc   = s.pc;
    have_ea   = 1'b0;
    ea_val    = s.ea;
    sel_acc   = s.ir[IR_ACC_SEL] ? s.acc_two : s.acc_one;
    sum       = 17'h00000;
    step      = 17'h00000;
    alter     = 19'h00000;
    srg_skip  = 1'b0;

    unique case (s.phase)
      PH_IDLE: begin
      end
      PH_DECODE: begin
        if (s.ir[14:12] != 3'b000) begin
          // base plus offset in base-relative mode when the page bit is clear
          // low ten bits are the offset
          if (s.ir[IR_PAGE])
            ea_val = {s.pc[14:10], s.ir[9:0]};
          else if (s.base_mode)
            ea_val = 15'(s.base[14:0] + {5'h00, s.ir[9:0]});
          else
            ea_val = {5'h00, s.ir[9:0]};
          if (s.ir[IR_INDIRECT]) begin
            next_s.ea    = ea_val;
            next_s.phase = PH_POINTER;
          end else begin
            have_ea = 1'b1;
          end
        end else if (s.ir[15:12] == 4'h0 && s.ir != 16'h0000) begin
          if (!s.ir[IR_GROUP]) begin
            // first position, clear extend, even test, second position
            step = shift_step(s.ir[8:6], s.ir[IR_EN_FIRST], sel_acc, s.extend);
            if (s.ir[IR_CLR_EXT])
              step[16] = 1'b0;
            // even test between the two positions
            srg_skip = s.ir[IR_SKIP_EVEN] & ~step[0];
            step = shift_step(s.ir[2:0], s.ir[IR_EN_SECOND], step[15:0], step[16]);
            next_s.extend = step[16];
            if (s.ir[IR_ACC_SEL])
              next_s.acc_two = step[15:0];
            else
              next_s.acc_one = step[15:0];
            take_skip = srg_skip;
          end else begin
            alter = alter_skip(s.ir, sel_acc, s.extend, s.overflow);
            next_s.overflow = alter[17];
            next_s.extend   = alter[16];
            if (s.ir[IR_ACC_SEL])
              next_s.acc_two = alter[15:0];
            else
              next_s.acc_one = alter[15:0];
            take_skip = alter[18];
          end
          done = 1'b1;
        end else begin
          // no-operation, and classes outside this block
          done = 1'b1;
        end
      end
      PH_POINTER: begin
        // follow pointers until the top bit is zero
        if (word_ready) begin
          if (word[15])
            next_s.ea = word[14:0];
          else begin
            have_ea = 1'b1;
            ea_val  = word[14:0];
          end
        end
      end
      PH_OPERAND: begin
        if (word_ready) begin
          unique case (op)
            OP_AND_ONE: next_s.acc_one = s.acc_one & word;
            OP_XOR_ONE: next_s.acc_one = s.acc_one ^ word;
            OP_IOR_ONE: next_s.acc_one = s.acc_one | word;
            // sum here; an add only ever sets extend and overflow, never clears them
            OP_ADD_ONE, OP_ADD_TWO: begin
              sum = {1'b0, sel_acc} + {1'b0, word};
              next_s.extend   = s.extend | sum[16];
              next_s.overflow = s.overflow |
                                ((sel_acc[15] == word[15]) & (sum[15] != sel_acc[15]));
              if (s.ir[IR_ACC_SEL])
                next_s.acc_two = sum[15:0];
              else
                next_s.acc_one = sum[15:0];
            end
            OP_CMP_ONE, OP_CMP_TWO: take_skip = (word != sel_acc);
            OP_LOAD_ONE: next_s.acc_one = word;
            OP_LOAD_TWO: next_s.acc_two = word;
            default: begin
            end
          endcase
          if (op == OP_INC_SKIP) begin
            next_s.wdata = 16'(word + 16'h0001);
            next_s.skip  = (word == 16'hffff);
            next_s.phase = PH_STORE;
          end else begin
            done = 1'b1;
          end
        end
      end
      PH_STORE: begin
        if (word_ready) begin
          if (acc_hit && !s.ea[0])
            next_s.acc_one = s.wdata;
          else if (acc_hit)
            next_s.acc_two = s.wdata;
          if (op == OP_SUB_JUMP) begin
            jump    = 1'b1;
            jump_pc = 15'(s.ea + 15'h0001);
          end
          take_skip = (op == OP_INC_SKIP) & s.skip;
          done      = 1'b1;
        end
      end
    endcase

    // effective address known: dispatch on the opcode
    if (have_ea) begin
      next_s.ea = ea_val;
      unique case (op)
        OP_JUMP: begin
          jump    = 1'b1;
          jump_pc = ea_val;
          done    = 1'b1;
        end
        OP_SUB_JUMP: begin
          // return address written at the target
          next_s.wdata = {1'b0, 15'(s.pc + 15'h0001)};
          next_s.phase = PH_STORE;
        end
        // stores take the accumulator, which stays
        OP_STORE_ONE: begin
          next_s.wdata = s.acc_one;
          next_s.phase = PH_STORE;
        end
        OP_STORE_TWO: begin
          next_s.wdata = s.acc_two;
          next_s.phase = PH_STORE;
        end
        default: next_s.phase = PH_OPERAND;
      endcase
    end

    if (done) begin
      next_s.phase = PH_IDLE;
      next_s.skip  = take_skip;
      next_s.pc    = jump ? jump_pc : 15'(s.pc + (take_skip ? 15'h0002 : 15'h0001));
    end

    // software port: answered one cycle after the request, only while idle
    if (s.bus_ack) begin
      next_s.bus_ack = 1'b0;
      if (avs_write) begin
        unique case (avs_address)
          REG_INSTR: begin
            next_s.ir    = merge16(s.ir, avs_writedata, avs_byteenable);
            next_s.phase = PH_DECODE;
          end
          REG_ACC1: next_s.acc_one = merge16(s.acc_one, avs_writedata, avs_byteenable);
          REG_ACC2: next_s.acc_two = merge16(s.acc_two, avs_writedata, avs_byteenable);
          REG_FLAGS: begin
            if (avs_byteenable[0]) begin
              next_s.extend    = avs_writedata[FLAG_EXTEND];
              next_s.overflow  = avs_writedata[FLAG_OVERFLOW];
              next_s.base_mode = avs_writedata[FLAG_BASE_MODE];
            end
          end
          REG_PC: next_s.pc = 15'(merge16({1'b0, s.pc}, avs_writedata, avs_byteenable));
          REG_BASE: next_s.base = merge16(s.base, avs_writedata, avs_byteenable);
          default: begin
          end
        endcase
      end
    end else if ((avs_read || avs_write) && s.phase == PH_IDLE) begin
      next_s.bus_ack = 1'b1;
      unique case (avs_address)
        REG_INSTR:  next_s.rdata = {16'h0000, s.ir};
        REG_ACC1:   next_s.rdata = {16'h0000, s.acc_one};
        REG_ACC2:   next_s.rdata = {16'h0000, s.acc_two};
        REG_FLAGS:  next_s.rdata = {29'h00000000, s.base_mode, s.overflow, s.extend};
        REG_PC:     next_s.rdata = {17'h00000, s.pc};
        REG_BASE:   next_s.rdata = {16'h0000, s.base};
        REG_STATUS: next_s.rdata = {30'h00000000, s.phase != PH_IDLE, s.skip};
        default:    next_s.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s           <= '0;
      s.phase     <= PH_IDLE;
      s.acc_one   <= ACC_RESET;
      s.acc_two   <= ACC_RESET;
      s.pc        <= PC_RESET;
      s.base      <= BASE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  wire decode_reg = (s.phase == PH_DECODE) && (s.ir[15:12] == 4'h0);

  chk_nop_keeps_regs: assert property (
    (s.phase == PH_DECODE && s.ir == 16'h0000) |=> (s.acc_one == $past(s.acc_one)) &&
      (s.acc_two == $past(s.acc_two)) && (s.extend == $past(s.extend)) &&
      (s.phase == PH_IDLE))
    else $error("no-operation word changed a register");

  chk_skip_adds_two: assert property (
    decode_reg |=> s.pc == 15'($past(s.pc) + (s.skip ? 15'h0002 : 15'h0001)))
    else $error("program counter step does not match skip");

  chk_rotate_four: assert property (
    (s.phase == PH_DECODE && s.ir == 16'h03c0) |=>
      s.acc_one == {$past(s.acc_one[11:0]), $past(s.acc_one[15:12])})
    else $error("rotate by four wrong");

  chk_disabled_rotate: assert property (
    (s.phase == PH_DECODE && s.ir == 16'h0180) |=>
      (s.acc_one == $past(s.acc_one)) && (s.extend == $past(s.acc_one[15])))
    else $error("disabled rotate through extend mishandled");

  chk_store_data: assert property (
    (mem_cmd.write && op == OP_STORE_ONE) |-> mem_cmd.writedata == s.acc_one)
    else $error("store data is not the accumulator");

  chk_pointer_chain: assert property (
    (s.phase == PH_POINTER && word_ready && word[15]) |=>
      (s.phase == PH_POINTER) && (s.ea == $past(word[14:0])))
    else $error("indirect chain not followed");

  chk_page_zero: assert property (
    (s.phase == PH_DECODE && s.ir[14:12] != 3'b000 && !s.ir[IR_PAGE] && !s.base_mode) |=>
      s.ea == {5'h00, $past(s.ir[9:0])})
    else $error("page zero address wrong");

  chk_base_offset: assert property (
    (s.phase == PH_DECODE && s.ir[14:12] != 3'b000 && !s.ir[IR_PAGE] && s.base_mode) |=>
      s.ea == 15'($past(s.base[14:0]) + {5'h00, $past(s.ir[9:0])}))
    else $error("base-relative address wrong");

  chk_return_word: assert property (
    (mem_cmd.write && op == OP_SUB_JUMP) |-> mem_cmd.writedata == {1'b0, 15'(s.pc + 15'h0001)})
    else $error("return address wrong");

  chk_acc_alias: assert property (
    (s.phase == PH_STORE && s.ea == 15'h0000) |-> !mem_cmd.write ##1 s.acc_one == $past(s.wdata))
    else $error("store to word zero missed the accumulator");

  cov_indirect: cover property (s.phase == PH_POINTER ##1 s.phase == PH_POINTER);
  cov_skip:     cover property (decode_reg ##1 s.skip);
  cov_sub_jump: cover property (mem_cmd.write && op == OP_SUB_JUMP && !avm_waitrequest);
  cov_inc_skip: cover property (s.phase == PH_STORE && op == OP_INC_SKIP && s.skip);

endmodule
`default_nettype wire

// [verif/msd_mem_model.sv]
/*
  word memory answering the decoder's memory master port.
  assumes one clock; slow sets the wait cycles and changes only while idle.
*/
`timescale 1ns/1ns
`default_nettype none
module msd_mem_model (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [1:0]               slow,
  input  wire msd_pkg::msd_mem_cmd_type mem_cmd,
  output logic [15:0]                   readdata,
  output logic                          waitrequest
);
  import msd_pkg::*;
  // ==========================================================
  // storage and wait counter
  logic [15:0] mem [0:32767];
  logic [1:0]  cnt;
  logic [15:0] last;
  wire         active = mem_cmd.read | mem_cmd.write;
  assign waitrequest = !(active && cnt == slow);
  // released data line shows the inverse of the last word
  assign readdata = (mem_cmd.read && !waitrequest) ? mem[mem_cmd.address] : ~last;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt  <= 2'h0;
      last <= 16'h0000;
    end else if (active && cnt != slow) begin
      cnt <= cnt + 2'h1;
    end else begin
      cnt <= 2'h0;
      if (active && mem_cmd.write) mem[mem_cmd.address] <= mem_cmd.writedata;
      if (active && mem_cmd.read) last <= mem[mem_cmd.address];
    end
  end
endmodule
`default_nettype wire

// [verif/memref_and_shift_skip_decoder_tb_top.sv]
/*
  self-checking bench: register tasks, instruction runs, expected values.
  assumes the package, the decoder and the memory model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module memref_and_shift_skip_decoder_tb_top;
  import msd_pkg::*;
  logic            clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]      avs_address = 5'h00;
  logic [31:0]     avs_writedata = 32'h0, avs_readdata;
  logic            avs_waitrequest, avm_waitrequest;
  logic [15:0]     avm_readdata, g;
  logic [1:0]      slow = 2'h0;
  logic [16:0]     x;
  msd_mem_cmd_type mem_cmd;
  int              n_mismatch = 0, num_checks = 0, cyc = 0;
  always #4 clock = ~clock;
  msd_decoder dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_cmd(mem_cmd),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest));
  msd_mem_model mem (.clock(clock), .rst(rst), .slow(slow), .mem_cmd(mem_cmd),
    .readdata(avm_readdata), .waitrequest(avm_waitrequest));
  // ==========================================================
  // verdict, timeout, compare
  task automatic final_report;
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] v);
    num_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask
  // ==========================================================
  // avalon master tasks
  task automatic acc(input logic r, input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_read <= r;
    avs_write <= !r;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    g = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    acc(1'b1, a, 16'h0);
    cmp($sformatf("reg %h", a), e, g);
  endtask
  task automatic run(input logic [15:0] i, a1, a2, input logic [2:0] f, input logic [14:0] p);
    acc(1'b0, REG_ACC1, a1);
    acc(1'b0, REG_ACC2, a2);
    acc(1'b0, REG_FLAGS, {13'h0, f});
    acc(1'b0, REG_PC, {1'b0, p});
    acc(1'b0, REG_INSTR, i);
  endtask
  function automatic logic [16:0] shf(input logic [2:0] c, input logic [16:0] v);
    case (c)
      SH_ARITH_LEFT:  return {v[16], v[15], v[13:0], 1'b0};
      SH_ARITH_RIGHT: return {v[16], v[15], v[15:1]};
      SH_ROT_LEFT:    return {v[16], v[14:0], v[15]};
      SH_ROT_RIGHT:   return {v[16], v[0], v[15:1]};
      SH_LEFT_CLR:    return {v[16], 1'b0, v[13:0], 1'b0};
      SH_EXT_RIGHT:   return {v[0], v[16], v[15:1]};
      SH_EXT_LEFT:    return {v[15], v[14:0], v[16]};
      default:        return {v[16], v[11:0], v[15:12]};
    endcase
  endfunction
  logic [15:0] sw [7] = '{16'h0408, 16'h0408, 16'h0419, 16'h0419, 16'h0418, 16'h0418, 16'h0c08};
  logic [15:0] sv [7] = '{16'h0002, 16'h0003, 16'h8001, 16'h8000, 16'h0001, 16'h8001, 16'h0004};
  logic [6:0]  sk = 7'b1010101;
  // ==========================================================
  // test sequence
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int a = 4; a < 32; a += 4) rc(5'(a), 16'h0000);
    run(16'h0000, 16'h1234, 16'h5678, 3'h3, 15'h0007);
    rc(REG_ACC1, 16'h1234);
    rc(REG_FLAGS, 16'h0003);
    for (int s = 0; s < 2; s++) for (int c = 0; c < 8; c++) begin
      x = shf(3'(c), {1'b1, 16'ha5c3});
      run({4'h0, 1'(s), 2'b01, 3'(c), 6'h0}, 16'ha5c3, 16'ha5c3, 3'h1, 15'h0);
      rc(s ? REG_ACC2 : REG_ACC1, x[15:0]);
      rc(REG_FLAGS, {15'h0, x[16]});
    end
    x = shf(SH_ROT_FOUR, shf(SH_ROT_LEFT, {1'b0, 16'ha5c3}));
    run({7'h01, SH_ROT_LEFT, 3'b010, SH_ROT_FOUR}, 16'ha5c3, 16'h0, 3'h0, 15'h0);
    rc(REG_ACC1, x[15:0]);
    run({7'h00, SH_EXT_LEFT, 6'h0}, 16'ha5c3, 16'h0, 3'h0, 15'h0);
    rc(REG_ACC1, 16'ha5c3);
    rc(REG_FLAGS, 16'h0001);
    for (int i = 0; i < 7; i++) begin
      run(sw[i], sv[i], sv[i], 3'h0, 15'h0010);
      rc(REG_PC, sk[6 - i] ? 16'h0012 : 16'h0011);
      rc(REG_STATUS, {15'h0, sk[6 - i]});
    end
    mem.mem[15'h0100] = 16'h1234;
    run({1'b0, OP_LOAD_ONE, 11'h100}, 16'h0, 16'h0, 3'h0, 15'h0);
    rc(REG_ACC1, 16'h1234);
    cmp("mem", 16'h1234, mem.mem[15'h0100]);
    mem.mem[15'h0c05] = 16'h4321;
    run({1'b0, OP_LOAD_TWO, 11'h405}, 16'h0, 16'h0, 3'h0, 15'h0c00);
    rc(REG_ACC2, 16'h4321);
    slow <= 2'h3;
    acc(1'b0, REG_BASE, 16'h2000);
    run({1'b0, OP_STORE_ONE, 11'h010}, 16'h00ff, 16'h0, 3'h4, 15'h0);
    rc(REG_ACC1, 16'h00ff);
    cmp("mem", 16'h00ff, mem.mem[15'h2010]);
    mem.mem[15'h0020] = 16'h8030;
    mem.mem[15'h0030] = 16'h0040;
    mem.mem[15'h0040] = 16'h5a5a;
    run({1'b1, OP_XOR_ONE, 11'h020}, 16'h0ff0, 16'h0, 3'h0, 15'h0);
    rc(REG_ACC1, 16'h55aa);
    cmp("mem", 16'h5a5a, mem.mem[15'h0040]);
    mem.mem[15'h0050] = 16'h0001;
    run({1'b0, OP_ADD_ONE, 11'h050}, 16'h7fff, 16'h0, 3'h0, 15'h0);
    rc(REG_ACC1, 16'h8000);
    rc(REG_FLAGS, 16'h0002);
    run({1'b0, OP_ADD_ONE, 11'h050}, 16'hffff, 16'h0, 3'h0, 15'h0);
    rc(REG_FLAGS, 16'h0001);
    run({1'b0, OP_LOAD_TWO, 11'h000}, 16'h6789, 16'h0, 3'h0, 15'h0);
    rc(REG_ACC2, 16'h6789);
    run({1'b0, OP_SUB_JUMP, 11'h300}, 16'h0, 16'h0, 3'h0, 15'h0005);
    rc(REG_PC, 16'h0301);
    cmp("mem", 16'h0006, mem.mem[15'h0300]);
    run({1'b0, OP_STORE_TWO, 11'h000}, 16'h0, 16'h1357, 3'h0, 15'h0);
    rc(REG_ACC1, 16'h1357);
    mem.mem[15'h0060] = 16'hffff;
    run({1'b0, OP_INC_SKIP, 11'h060}, 16'h0, 16'h0, 3'h0, 15'h0010);
    rc(REG_PC, 16'h0012);
    cmp("mem", 16'h0000, mem.mem[15'h0060]);
    run({1'b0, OP_CMP_ONE, 11'h050}, 16'h0002, 16'h0, 3'h0, 15'h0010);
    rc(REG_PC, 16'h0012);
    run({1'b0, OP_JUMP, 11'h523}, 16'h0, 16'h0, 3'h0, 15'h0c00);
    rc(REG_PC, 16'h0d23);
    final_report();
  end
endmodule
`default_nettype wire
